// ===== tpwm_pkg.sv
// package for the pwm timer channel: register map, field layout, constants
package tpwm_pkg;
  localparam logic [2:0] ADDR_RUN_CTL = 3'h0;
  localparam logic [2:0] ADDR_MODE_CTL = 3'h1;
  localparam logic [2:0] ADDR_PIN_CTL = 3'h2;
  localparam logic [2:0] ADDR_EDGE_CTL = 3'h3;
  localparam logic [2:0] ADDR_COUNTER = 3'h4;
  localparam logic [2:0] ADDR_PERIOD = 3'h5;
  localparam logic [2:0] ADDR_DUTY = 3'h6;
  // run control fields
  localparam int RUN_BIT_POS = 7;
  localparam int PRESCALE_LSB = 0;
  // mode control fields
  localparam int SOFT_TRIG_POS = 6;
  localparam int EVENT_SEL_POS = 5;
  localparam int MODE_LSB = 0;
  // pin control fields
  localparam int OUT1_POL_POS = 3;
  localparam int OUT1_EN_POS = 2;
  localparam int OUT0_LVL_POS = 1;
  localparam int OUT0_EN_POS = 0;
  // edge control field
  localparam int EDGE_SEL_LSB = 2;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h3;
  localparam logic [2:0] MODE_PWM = 3'h4;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [7:0] CTL_RESET = 8'h00;
  localparam logic [15:0] CCR_RESET = 16'h0000;
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  typedef struct packed {
    logic [2:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tpwm_bus_s;
  typedef struct packed {
    logic out1_o;
    logic out1_oe;
    logic out0_o;
    logic out0_oe;
  } tpwm_pins_s;
endpackage

// ===== tpwm_top.sv
// pwm output mode channel of a 16-bit timer/event counter
// What this block does
// - pwm mode is selected when the three-bit mode field is 100
// - setting run wraps counter FFFF to 0000 and starts the waveform
// - active width equals duty value times count clock period
// - period equals period value plus one count clocks; counter then restarts
// - out0 toggles once per pwm period, a half-rate square wave
// - while running, compare writes reach shadows only when the counter clears at period match
// - only a duty write arms the reload of both shadows
// - period irq fires on the count after period match, as counter clears
// - duty irq fires in the same count as the duty match
// - one-shot mode never starts the counter, so its duty irq never fires
// - duty 0000 gives 0%; with period FFFF the duty irq still fires
// - duty of period plus one gives 100%, impossible with period FFFF
// - out1 polarity bit 0 is active high, 1 is active low
// - each pin has a drive enable; disabled out0 shows its level bit
// - event select picks external events over the prescaled clock
// - run bit stops or enables counting; prescaler writable alongside
// - a two-bit field picks the active edge of the event input
//
// Implementation choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module tpwm_top #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic clk_en_i,
  input wire tpwm_pkg::tpwm_bus_s bus_i,
  output logic [15:0] rdata_o,
  input wire logic event_in_i,
  output tpwm_pkg::tpwm_pins_s pins_o,
  output logic period_match_irq_o,
  output logic duty_match_irq_o
);
  typedef enum logic [1:0] {
    TPWM_IDLE = 2'b01,
    TPWM_RUN = 2'b10
  } tpwm_state_e;

  //////////////////////////////////////////////////////////////////////////
  function automatic logic wr_hit(input tpwm_pkg::tpwm_bus_s b,
                                  input logic [2:0] a);
    wr_hit = b.wr && (b.addr == a);
  endfunction

  logic [7:0] run_ctl_q;
  logic [7:0] mode_ctl_q;
  logic [7:0] pin_ctl_q;
  logic [7:0] edge_ctl_q;
  logic [CNT_W-1:0] period_q;
  logic [CNT_W-1:0] duty_q;
  logic [CNT_W-1:0] period_shadow_q;
  logic [CNT_W-1:0] duty_shadow_q;
  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic reload_armed_q;
  logic out1_act_q;
  logic out0_tgl_q;
  logic [7:0] presc_q;
  logic event_prev_q;
  logic period_irq_q;
  logic duty_irq_q;
  tpwm_state_e state_q;
  tpwm_state_e state_d;

  //////////////////////////////////////////////////////////////////////////
  // decoding
  wire run_bit = run_ctl_q[tpwm_pkg::RUN_BIT_POS];
  wire [2:0] presc_sel = run_ctl_q[tpwm_pkg::PRESCALE_LSB +: 3];
  wire [2:0] mode = mode_ctl_q[tpwm_pkg::MODE_LSB +: 3];
  wire event_sel = mode_ctl_q[tpwm_pkg::EVENT_SEL_POS];
  wire out1_pol = pin_ctl_q[tpwm_pkg::OUT1_POL_POS];
  wire out1_en = pin_ctl_q[tpwm_pkg::OUT1_EN_POS];
  wire out0_lvl = pin_ctl_q[tpwm_pkg::OUT0_LVL_POS];
  wire out0_en = pin_ctl_q[tpwm_pkg::OUT0_EN_POS];
  wire [1:0] edge_sel = edge_ctl_q[tpwm_pkg::EDGE_SEL_LSB +: 2];
  wire pwm_mode = (mode == tpwm_pkg::MODE_PWM);
  wire os_mode = (mode == tpwm_pkg::MODE_ONE_SHOT);
  wire wr_period = wr_hit(bus_i, tpwm_pkg::ADDR_PERIOD);
  wire wr_duty = wr_hit(bus_i, tpwm_pkg::ADDR_DUTY);

  // prescaled tick: divide by 2^sel; event edge per selected polarity
  wire presc_tick = (presc_sel == 3'h0) ? 1'b1 :
                    (presc_q[presc_sel - 3'h1 +: 1] == 1'b1) &&
                    ((presc_q & ((8'h01 << (presc_sel - 3'h1)) - 8'h01))
                     == ((8'h01 << (presc_sel - 3'h1)) - 8'h01));
  wire ev_rise = event_in_i && !event_prev_q;
  wire ev_fall = !event_in_i && event_prev_q;
  wire ev_tick = ((edge_sel == tpwm_pkg::EDGE_RISE) && ev_rise) ||
                 ((edge_sel == tpwm_pkg::EDGE_FALL) && ev_fall) ||
                 ((edge_sel == tpwm_pkg::EDGE_BOTH) && (ev_rise || ev_fall));
  wire count_tick = event_sel ? ev_tick : presc_tick;
  wire running = (state_q == TPWM_RUN);
  wire adv = running && count_tick;
  wire at_period = (count_q == period_shadow_q);
  wire wrap = adv && at_period;
  // a start or an armed wrap loads the duty shadow in the same edge
  wire [CNT_W-1:0] next_duty = (!running || (wrap && reload_armed_q)) ?
                               duty_q : duty_shadow_q;
  wire step = (state_d == TPWM_RUN) && (adv || !running);
  wire duty_hit = step && (count_d == next_duty);

  //////////////////////////////////////////////////////////////////////////
  // state and counter next values
  always_comb begin
    state_d = state_q;
    case (state_q)
      TPWM_IDLE: begin
        if (run_bit && pwm_mode) begin
          state_d = TPWM_RUN;
        end
      end
      TPWM_RUN: begin
        if (!run_bit || !pwm_mode) begin
          state_d = TPWM_IDLE;
        end
      end
      default: state_d = TPWM_IDLE;
    endcase
  end

  always_comb begin
    if (state_q == TPWM_IDLE) begin
      count_d = state_d == TPWM_RUN ? tpwm_pkg::CNT_ZERO : tpwm_pkg::CNT_MAX;
    end else if (state_d == TPWM_IDLE) begin
      count_d = tpwm_pkg::CNT_MAX;
    end else if (wrap) begin
      count_d = tpwm_pkg::CNT_ZERO;
    end else if (adv) begin
      count_d = count_q + 16'h0001;
    end else begin
      count_d = count_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // registers; a write to run control can set prescaler and run together
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      run_ctl_q <= tpwm_pkg::CTL_RESET;
      mode_ctl_q <= tpwm_pkg::CTL_RESET;
      pin_ctl_q <= tpwm_pkg::CTL_RESET;
      edge_ctl_q <= tpwm_pkg::CTL_RESET;
      period_q <= tpwm_pkg::CCR_RESET;
      duty_q <= tpwm_pkg::CCR_RESET;
    end else if (clk_en_i) begin
      if (wr_hit(bus_i, tpwm_pkg::ADDR_RUN_CTL)) begin
        run_ctl_q <= bus_i.wdata[7:0];
      end
      if (wr_hit(bus_i, tpwm_pkg::ADDR_MODE_CTL)) begin
        // soft trigger is write-only and not kept
        mode_ctl_q <= bus_i.wdata[7:0] & 8'hBF;
      end
      if (wr_hit(bus_i, tpwm_pkg::ADDR_PIN_CTL)) begin
        pin_ctl_q <= bus_i.wdata[7:0];
      end
      if (wr_hit(bus_i, tpwm_pkg::ADDR_EDGE_CTL)) begin
        edge_ctl_q <= bus_i.wdata[7:0];
      end
      if (wr_period) begin
        period_q <= bus_i.wdata;
      end
      if (wr_duty) begin
        duty_q <= bus_i.wdata;
      end
    end
  end

  // shadows load freely while stopped, else only at an armed wrap
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      period_shadow_q <= tpwm_pkg::CCR_RESET;
      duty_shadow_q <= tpwm_pkg::CCR_RESET;
      reload_armed_q <= 1'b0;
    end else if (clk_en_i) begin
      if (!running) begin
        period_shadow_q <= period_q;
        duty_shadow_q <= duty_q;
        reload_armed_q <= 1'b0;
      end else begin
        if (wrap && reload_armed_q) begin
          period_shadow_q <= period_q;
          duty_shadow_q <= duty_q;
        end
        // a duty write in the wrap cycle stays armed: set wins
        if (wr_duty) begin
          reload_armed_q <= 1'b1;
        end else if (wrap) begin
          reload_armed_q <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      state_q <= TPWM_IDLE;
      count_q <= tpwm_pkg::CNT_MAX;
      presc_q <= 8'h00;
      event_prev_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      count_q <= count_d;
      presc_q <= running ? presc_q + 8'h01 : 8'h00;
      event_prev_q <= event_in_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // waveform: asserted from the clear to the duty match, so duty 0 gives
  // 0% and duty = period+1 never matches, giving 100%
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      out1_act_q <= 1'b0;
      out0_tgl_q <= 1'b0;
      period_irq_q <= 1'b0;
      duty_irq_q <= 1'b0;
    end else if (clk_en_i) begin
      period_irq_q <= wrap;
      duty_irq_q <= 1'b0;
      if (!running) begin
        out1_act_q <= (state_d == TPWM_RUN) && (duty_q != tpwm_pkg::CNT_ZERO);
        out0_tgl_q <= (state_d == TPWM_RUN) ? ~out0_tgl_q : 1'b0;
      end else if (wrap) begin
        // next period starts at 0: assert unless the new duty is 0
        out1_act_q <= (next_duty !=
                       tpwm_pkg::CNT_ZERO);
        out0_tgl_q <= ~out0_tgl_q;
      end else if (adv && (count_q + 16'h0001 == duty_shadow_q)) begin
        out1_act_q <= 1'b0;
      end
      // duty irq rises with the count that lands on the duty value, in step
      // with the out1 change rather than one count later
      if (duty_hit && (pwm_mode || os_mode)) begin
        duty_irq_q <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins and read data
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      pins_o <= '0;
      rdata_o <= 16'h0000;
    end else if (clk_en_i) begin
      pins_o.out1_oe <= out1_en;
      pins_o.out1_o <= out1_en & (out1_act_q ^ out1_pol);
      pins_o.out0_oe <= out0_en;
      pins_o.out0_o <= out0_en ? (out0_tgl_q ^ out0_lvl) : out0_lvl;
      rdata_o <= 16'h0000;
      if (bus_i.rd) begin
        case (bus_i.addr)
          tpwm_pkg::ADDR_RUN_CTL: rdata_o <= {8'h00, run_ctl_q};
          tpwm_pkg::ADDR_MODE_CTL: rdata_o <= {8'h00, mode_ctl_q};
          tpwm_pkg::ADDR_PIN_CTL: rdata_o <= {8'h00, pin_ctl_q};
          tpwm_pkg::ADDR_EDGE_CTL: rdata_o <= {8'h00, edge_ctl_q};
          tpwm_pkg::ADDR_COUNTER: rdata_o <= count_q;
          tpwm_pkg::ADDR_PERIOD: rdata_o <= period_q;
          tpwm_pkg::ADDR_DUTY: rdata_o <= duty_q;
          default: rdata_o <= 16'h0000;
        endcase
      end
    end
  end

  assign period_match_irq_o = period_irq_q;
  assign duty_match_irq_o = duty_irq_q;

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_mode_gates_run: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) running |-> $past(pwm_mode) || !clk_en_i ||
      $past(running))
    else $error("counter running outside pwm mode");

  a_start_from_zero: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && !running && state_d == TPWM_RUN
      |=> count_q == 16'h0000)
    else $error("counter did not start at zero");

  a_wrap_clears: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && wrap && run_bit && pwm_mode
      |=> count_q == 16'h0000)
    else $error("counter did not clear at period match");

  a_period_irq: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && wrap |=> period_match_irq_o)
    else $error("period irq missing after wrap");

  a_shadow_hold: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && running && !wrap
      |=> $stable(duty_shadow_q) && $stable(period_shadow_q))
    else $error("shadow changed outside a wrap");

  a_period_no_arm: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && running && !reload_armed_q &&
      !wr_duty |=> !reload_armed_q)
    else $error("reload armed without duty write");

  a_out0_toggles: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && running && wrap && run_bit &&
      pwm_mode |=> out0_tgl_q != $past(out0_tgl_q))
    else $error("out0 did not toggle at wrap");

  a_out0_idle: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && !out0_en |=> pins_o.out0_o ==
      $past(out0_lvl))
    else $error("disabled out0 does not show level bit");

  //////////////////////////////////////////////////////////////////////////
  // named steps shared by the waveform checks
  sequence s_stall;
    !clk_en_i;
  endsequence

  sequence s_start;
    clk_en_i && !running && (state_d == TPWM_RUN);
  endsequence

  sequence s_count_step;
    clk_en_i && running && adv && !wrap && (state_d == TPWM_RUN);
  endsequence

  sequence s_quiet_event;
    clk_en_i && running && event_sel && !ev_tick && (state_d == TPWM_RUN);
  endsequence

  a_duty_irq_align: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) duty_match_irq_o |-> running &&
      count_q == duty_shadow_q)
    else $error("duty irq not aligned with duty match");

  a_out1_off_at_duty: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) running && count_q == duty_shadow_q
      |-> !out1_act_q)
    else $error("out1 still active at duty match");

  a_out1_on_at_clear: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) running && count_q == tpwm_pkg::CNT_ZERO &&
      duty_shadow_q != tpwm_pkg::CNT_ZERO |-> out1_act_q)
    else $error("out1 not active at period start");

  a_full_duty: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) running &&
      period_shadow_q != tpwm_pkg::CNT_MAX &&
      duty_shadow_q - period_shadow_q == CNT_W'(1) |-> out1_act_q)
    else $error("full duty did not hold out1 active");

  a_period_irq_zero: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) period_match_irq_o && running
      |-> count_q == tpwm_pkg::CNT_ZERO)
    else $error("period irq without counter clear");

  a_freeze_holds: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) s_stall |=> $stable(count_q) &&
      $stable(state_q) && $stable(pins_o))
    else $error("state moved while clock enable was low");

  a_start_duty: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) s_start |=> running &&
      out1_act_q == (duty_shadow_q != tpwm_pkg::CNT_ZERO))
    else $error("waveform did not start with the duty value");

  a_count_step: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) s_count_step |=> count_q ==
      $past(count_q) + CNT_W'(1))
    else $error("counter did not advance by one on a tick");

  a_event_no_tick: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) s_quiet_event |=> $stable(count_q))
    else $error("counter moved without a selected event edge");

  a_stopped_count: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) !running |-> count_q == tpwm_pkg::CNT_MAX)
    else $error("stopped counter not parked at FFFF");

  a_out1_off_disabled: assert property (@(posedge ref_clk_i)
    disable iff (sys_rst_i) clk_en_i && !out1_en |=> !pins_o.out1_o &&
      !pins_o.out1_oe)
    else $error("disabled out1 still driven");
endmodule

// ===== tpwm_load.sv
// load model on the pulse pins: measures out1 high time per out0 half-cycle
`timescale 1ns/1ps
module tpwm_load (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire tpwm_pkg::tpwm_pins_s pins_i,
  output logic [31:0] hi_o,
  output logic [31:0] len_o
);
  logic [31:0] hi_q;
  logic [31:0] len_q;
  logic prev_q;
  logic edge_w;
  // a toggle of out0 marks the start of each pwm period
  assign edge_w = pins_i.out0_o != prev_q;
  always_ff @(posedge ref_clk_i) begin
    prev_q <= pins_i.out0_o;
    if (sys_rst_i) begin
      hi_q <= '0;
      len_q <= '0;
      hi_o <= '0;
      len_o <= '0;
    end else if (edge_w) begin
      hi_o <= hi_q;
      len_o <= len_q;
      hi_q <= {31'h0, pins_i.out1_o};
      len_q <= 32'h1;
    end else begin
      hi_q <= hi_q + {31'h0, pins_i.out1_o};
      len_q <= len_q + 32'h1;
    end
  end
endmodule

// ===== timer_pwm_output_mode_tb.sv
// self-checking bench for the pwm output mode channel
`timescale 1ns/1ps
module timer_pwm_output_mode_tb;
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic event_in_i = 1'b0;
  logic clk_en_i = 1'b1;
  tpwm_pkg::tpwm_bus_s bus_i = '0;
  logic [15:0] rdata_o;
  tpwm_pkg::tpwm_pins_s pins_o;
  logic period_match_irq_o;
  logic duty_match_irq_o;
  logic [31:0] hi_w;
  logic [31:0] len_w;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  logic [15:0] seed = 16'hA18A;
  logic [15:0] p, d, v, v2;
  logic [31:0] g;
  logic [2:0] ps;
  logic pol;
  logic [15:0] ev_exp [4] = '{16'h0000, 16'h0005, 16'h0005, 16'h000A};
  tpwm_top uut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .clk_en_i(clk_en_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .event_in_i(event_in_i), .pins_o(pins_o),
    .period_match_irq_o(period_match_irq_o),
    .duty_match_irq_o(duty_match_irq_o));
  tpwm_load load (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .pins_i(pins_o), .hi_o(hi_w), .len_o(len_w));
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic end_of_test();
    if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] x);
    @(posedge ref_clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= x;
    bus_i.wr <= 1'b1;
    @(posedge ref_clk_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [15:0] x);
    @(posedge ref_clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge ref_clk_i);
    bus_i.rd <= 1'b0;
    #1 x = rdata_o;
  endtask
  // waits for n period interrupts, each one cycle long
  task automatic wait_per(input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk_i);
      #1;
      while (period_match_irq_o !== 1'b1) begin
        @(posedge ref_clk_i);
        #1;
      end
    end
  endtask
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      n_errors++;
      end_of_test();
    end
  end
  initial begin
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    // writes to the counter and to an unmapped index must be ignored
    wr(tpwm_pkg::ADDR_COUNTER, 16'h1234);
    wr(3'h7, 16'h5A5A);
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], v);
      check(v, (i == 4) ? 32'hFFFF : 32'h0);
    end
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      p = 16'h3 + seed[3:0];
      seed = lfsr(seed);
      d = seed % (p + 16'h2);
      if (i == 0) d = 16'h0000;
      if (i == 1) d = p + 16'h1;
      ps = {2'b00, seed[4]};
      pol = seed[5];
      wr(tpwm_pkg::ADDR_RUN_CTL, 16'h0000);
      wr(tpwm_pkg::ADDR_PERIOD, p);
      wr(tpwm_pkg::ADDR_DUTY, d);
      wr(tpwm_pkg::ADDR_PIN_CTL, {12'h0, pol, 3'b101});
      wr(tpwm_pkg::ADDR_MODE_CTL, {13'h0, tpwm_pkg::MODE_PWM});
      wr(tpwm_pkg::ADDR_RUN_CTL, {8'h0, 5'h10, ps});
      wait_per(3);
      check(len_w, 32'(p + 16'h1) << ps);
      check(hi_w, pol ? 32'(p + 16'h1 - d) << ps : 32'(d) << ps);
      check({pins_o.out1_oe, pins_o.out0_oe}, 32'h3);
      if (d != 0 && d <= p) begin
        wait_per(1);
        g = 0;
        while (duty_match_irq_o !== 1'b1 && g < 5000) begin
          @(posedge ref_clk_i);
          #1 g++;
        end
        check(g, 32'(d) << ps);
      end
    end
    // period-only write must not reload until duty is rewritten
    wait_per(1);
    wr(tpwm_pkg::ADDR_PERIOD, p + 16'h4);
    wait_per(3);
    check(len_w, 32'(p + 16'h1) << ps);
    wait_per(1);
    wr(tpwm_pkg::ADDR_DUTY, d);
    wait_per(3);
    check(len_w, 32'(p + 16'h5) << ps);
    // a low clock enable stretches the period by the stalled cycles
    @(posedge ref_clk_i);
    clk_en_i <= 1'b0;
    repeat (7) @(posedge ref_clk_i);
    clk_en_i <= 1'b1;
    wait_per(2);
    check(len_w, (32'(p + 16'h5) << ps) + 32'h7);
    wr(tpwm_pkg::ADDR_PIN_CTL, 16'h0002);
    repeat (3) @(posedge ref_clk_i);
    #1 check({pins_o.out1_oe, pins_o.out1_o, pins_o.out0_oe,
      pins_o.out0_o}, 32'h1);
    wr(tpwm_pkg::ADDR_PIN_CTL, 16'h0000);
    repeat (3) @(posedge ref_clk_i);
    #1 check({pins_o.out1_oe, pins_o.out1_o, pins_o.out0_oe,
      pins_o.out0_o}, 32'h0);
    wr(tpwm_pkg::ADDR_RUN_CTL, 16'h0000);
    rd(tpwm_pkg::ADDR_COUNTER, v);
    repeat (4) @(posedge ref_clk_i);
    rd(tpwm_pkg::ADDR_COUNTER, v2);
    check(v2, v);
    wr(tpwm_pkg::ADDR_PERIOD, 16'h00FF);
    wr(tpwm_pkg::ADDR_DUTY, 16'h0010);
    for (int e = 0; e < 4; e++) begin
      wr(tpwm_pkg::ADDR_RUN_CTL, 16'h0000);
      wr(tpwm_pkg::ADDR_MODE_CTL, 16'h0024);
      wr(tpwm_pkg::ADDR_EDGE_CTL, 16'(e) << tpwm_pkg::EDGE_SEL_LSB);
      // prescale field set to 7 must be ignored in event mode
      wr(tpwm_pkg::ADDR_RUN_CTL, 16'h0087);
      for (int k = 0; k < 5; k++) begin
        @(posedge ref_clk_i);
        event_in_i <= 1'b1;
        repeat (4) @(posedge ref_clk_i);
        event_in_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
      end
      rd(tpwm_pkg::ADDR_COUNTER, v);
      check(v, ev_exp[e]);
    end
    end_of_test();
  end
endmodule
